// [hdl/sctm_top.sv]
// sctm_top: scan cycle time monitor with its register file
// assumes one clock, synchronous reset, an Avalon-MM master on the same clock
//
// Summary of operation
// - no supervision until software marks startup finished
// - overrun without installed handler raises time error and stops
// - overrun with installed handler dispatches the handler instead
// - retrigger restarts timer only from cyclic context, ignored from handler
// - second overrun in one scan without retrigger stops at once
// - communication slice every 100 ms, length set by load percentage
// - fixed minimum scan held within one millisecond
// - early finish fills remaining time with diagnostics and communication
// - scan longer than minimum completes normally, no reaction
// - maximum always supervised, 1 to 6000 ms, default 150 ms
// - minimum disabled by default, range 1 ms to maximum
// - without minimum, next scan starts right after the previous one
// - handler receives fault cause code 01 for maximum overrun
`timescale 1ns/100ps
`default_nettype none
module sctm_top #(
  parameter int unsigned CYC_MS = sctm_pkg::CYC_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic             stop_o,
  output logic             handler_req_o,
  output logic      [7:0]  fault_cause_code_o,
  output logic             idle_fill_o,
  output logic             scan_start_o,
  output logic             comm_slice_o
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef logic [12:0] sctm_ms_t;
  sctm_pkg::sctm_state_e state_r, state_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  sctm_ms_t    maxt_r, maxt_nxt, mint_r, mint_nxt, scan_ms_r, scan_ms_nxt;
  logic [6:0]  comm_r, comm_nxt, slice_ms_r, slice_ms_nxt;
  logic [15:0] sub_r, sub_nxt, fsub_r, fsub_nxt;
  logic        ovr_seen_r, ovr_seen_nxt, hdl_r, hdl_nxt;
  logic [7:0]  cause_r, cause_nxt;
  logic        stop_r, idle_r, start_r, slice_r;
  logic        acc, wr, ms_tick, f_tick, running, ovr_ev, new_scan;
  logic [4:0]  cmd;
  logic [31:0] wmask, wval;

  assign acc     = (read_i | write_i) & wait_r;
  // a write lands on the answer edge, when waitrequest is already low
  assign wr      = write_i & ~wait_r;
  assign wmask   = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign wval    = writedata_i & wmask;
  assign cmd     = (wr && address_i == sctm_pkg::OFF_CMD) ? wval[4:0] : 5'h00;
  assign running = (state_r == sctm_pkg::ST_SCAN) || (state_r == sctm_pkg::ST_IDLE);
  assign ms_tick = (sub_r == 16'(CYC_MS - 1));
  assign f_tick  = (fsub_r == 16'(CYC_MS - 1));
  assign ovr_ev  = (state_r == sctm_pkg::ST_SCAN) && ms_tick &&
                   (scan_ms_r + 13'h0001 >= maxt_r);

  function automatic sctm_ms_t clamp(input sctm_ms_t v, input sctm_ms_t hi);
    clamp = (v < sctm_pkg::MAXT_MIN) ? sctm_pkg::MAXT_MIN : ((v > hi) ? hi : v);
  endfunction : clamp

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then a one-cycle answer
  always_comb
  begin
    wait_nxt  = ~acc;
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    maxt_nxt  = maxt_r;
    mint_nxt  = mint_r;
    comm_nxt  = comm_r;
    if (read_i & acc)
    begin
      unique case (address_i)
        sctm_pkg::OFF_CTRL: rdata_nxt = {29'h0000_0000, ctrl_r};
        sctm_pkg::OFF_MAXT: rdata_nxt = {19'h0_0000, maxt_r};
        sctm_pkg::OFF_MINT: rdata_nxt = {19'h0_0000, mint_r};
        sctm_pkg::OFF_COMM: rdata_nxt = {25'h000_0000, comm_r};
        sctm_pkg::OFF_STAT: rdata_nxt = {3'h0, scan_ms_r, cause_r, 3'h0, slice_r,
                                         ovr_seen_r, hdl_r, state_r};
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (address_i)
        sctm_pkg::OFF_CTRL: ctrl_nxt = wval[2:0];
        sctm_pkg::OFF_MAXT:
        begin
          maxt_nxt = clamp(wval[12:0], sctm_pkg::MAXT_MAX);
          mint_nxt = clamp(mint_r, maxt_nxt);
        end
        sctm_pkg::OFF_MINT: mint_nxt = clamp(wval[12:0], maxt_r);
        sctm_pkg::OFF_COMM:
          comm_nxt = (wval[6:0] > sctm_pkg::COMM_MAX) ? sctm_pkg::COMM_MAX : wval[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r  <= sctm_pkg::CTRL_RST;
      maxt_r  <= sctm_pkg::MAXT_RST;
      mint_r  <= sctm_pkg::MINT_RST;
      comm_r  <= sctm_pkg::COMM_RST;
    end
    else
    begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r  <= ctrl_nxt;
      maxt_r  <= maxt_nxt;
      mint_r  <= mint_nxt;
      comm_r  <= comm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scan supervision
  always_comb
  begin
    state_nxt    = state_r;
    scan_ms_nxt  = scan_ms_r;
    sub_nxt      = ms_tick ? 16'h0000 : sub_r + 16'h0001;
    ovr_seen_nxt = ovr_seen_r;
    hdl_nxt      = hdl_r & ~cmd[sctm_pkg::CMD_HDL_DONE];
    cause_nxt    = cause_r;
    new_scan     = 1'b0;
    if (ms_tick)
      scan_ms_nxt = scan_ms_r + 13'h0001;
    unique case (state_r)
      sctm_pkg::ST_BOOT:
      begin
        sub_nxt = 16'h0000;
        if (ctrl_r[sctm_pkg::CTRL_START_DONE])
          new_scan = 1'b1;
      end
      sctm_pkg::ST_SCAN:
      begin
        if (ovr_ev)
        begin
          if (ovr_seen_r || !ctrl_r[sctm_pkg::CTRL_HANDLER])
            state_nxt = sctm_pkg::ST_STOP;
          else
          begin
            hdl_nxt      = 1'b1;
            cause_nxt    = sctm_pkg::CAUSE_MAXT;
            ovr_seen_nxt = 1'b1;
            scan_ms_nxt  = 13'h0000;
            sub_nxt      = 16'h0000;
          end
        end
        else if (cmd[sctm_pkg::CMD_SCAN_END])
        begin
          // a scan past the minimum simply ends, no reaction
          if (ctrl_r[sctm_pkg::CTRL_FIX_EN] && scan_ms_r < mint_r)
            state_nxt = sctm_pkg::ST_IDLE;
          else
            new_scan = 1'b1;
        end
        else if (cmd[sctm_pkg::CMD_RETRIG] && !cmd[sctm_pkg::CMD_RETRIG_HCTX])
        begin
          scan_ms_nxt  = 13'h0000;
          sub_nxt      = 16'h0000;
          ovr_seen_nxt = 1'b0;
        end
      end
      sctm_pkg::ST_IDLE:
        if (ms_tick && scan_ms_r + 13'h0001 >= mint_r)
          new_scan = 1'b1;
      sctm_pkg::ST_STOP:
        if (cmd[sctm_pkg::CMD_RESTART])
        begin
          // a stale overrun must not follow the cpu back into startup
          state_nxt    = sctm_pkg::ST_BOOT;
          ovr_seen_nxt = 1'b0;
        end
    endcase
    if (new_scan)
    begin
      state_nxt    = sctm_pkg::ST_SCAN;
      scan_ms_nxt  = 13'h0000;
      sub_nxt      = 16'h0000;
      ovr_seen_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // free-running 100 ms frame, so very short scans cannot starve the slice
  always_comb
  begin
    fsub_nxt     = f_tick ? 16'h0000 : fsub_r + 16'h0001;
    slice_ms_nxt = slice_ms_r;
    if (f_tick)
      slice_ms_nxt = (slice_ms_r == 7'(sctm_pkg::SLICE_MS - 1)) ? 7'h00
                                                                 : slice_ms_r + 7'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= sctm_pkg::ST_BOOT;
      scan_ms_r  <= 13'h0000;
      sub_r      <= 16'h0000;
      fsub_r     <= 16'h0000;
      slice_ms_r <= 7'h00;
      ovr_seen_r <= 1'b0;
      hdl_r      <= 1'b0;
      cause_r    <= 8'h00;
      stop_r     <= 1'b0;
      idle_r     <= 1'b0;
      start_r    <= 1'b0;
      slice_r    <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      scan_ms_r  <= scan_ms_nxt;
      sub_r      <= sub_nxt;
      fsub_r     <= fsub_nxt;
      slice_ms_r <= slice_ms_nxt;
      ovr_seen_r <= ovr_seen_nxt;
      hdl_r      <= hdl_nxt & (state_nxt != sctm_pkg::ST_STOP);
      cause_r    <= cause_nxt;
      stop_r     <= (state_nxt == sctm_pkg::ST_STOP);
      idle_r     <= (state_nxt == sctm_pkg::ST_IDLE);
      start_r    <= new_scan;
      slice_r    <= (state_nxt == sctm_pkg::ST_SCAN || state_nxt == sctm_pkg::ST_IDLE)
                    && (slice_ms_nxt < comm_r);
    end
  end

  assign readdata_o         = rdata_r;
  assign waitrequest_o      = wait_r;
  assign stop_o             = stop_r;
  assign handler_req_o      = hdl_r;
  assign fault_cause_code_o = cause_r;
  assign idle_fill_o        = idle_r;
  assign scan_start_o       = start_r;
  assign comm_slice_o       = slice_r;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_boot_quiet: assert property (state_r == sctm_pkg::ST_BOOT |-> !hdl_r && !ovr_seen_r)
    else $error("supervision active before startup finished");
  a_stop_nohdl: assert property (ovr_ev && !ctrl_r[sctm_pkg::CTRL_HANDLER] |=> stop_o)
    else $error("overrun without handler did not stop");
  a_hdl_dispatch: assert property (ovr_ev && ctrl_r[sctm_pkg::CTRL_HANDLER] && !ovr_seen_r
    |=> handler_req_o && !stop_o && fault_cause_code_o == sctm_pkg::CAUSE_MAXT)
    else $error("handler not dispatched with cause 01");
  a_retrig_hctx: assert property (state_r == sctm_pkg::ST_SCAN && !ovr_ev && !cmd[0]
    && cmd[2] |=> ovr_seen_r == $past(ovr_seen_r) && scan_ms_r >= $past(scan_ms_r))
    else $error("retrigger from handler context took effect");
  a_double_stop: assert property (ovr_ev && ovr_seen_r |=> stop_o && state_r == sctm_pkg::ST_STOP)
    else $error("second overrun did not stop");
  a_slice_len: assert property (running && f_tick && slice_ms_r == 7'h63 && comm_r != 7'h00
    && state_nxt != sctm_pkg::ST_STOP |=> comm_slice_o)
    else $error("communication slice missing at frame start");
  a_min_hold: assert property (state_r == sctm_pkg::ST_IDLE |-> scan_ms_r < mint_r
    && ctrl_r[sctm_pkg::CTRL_FIX_EN] && idle_fill_o)
    else $error("idle fill outside minimum window");
  a_long_scan: assert property (state_r == sctm_pkg::ST_SCAN && cmd[0] && !ovr_ev
    && scan_ms_r >= mint_r |=> scan_start_o && !stop_o && !idle_fill_o
    && (!handler_req_o || $past(hdl_r)))
    else $error("reaction to scan beyond minimum");
  a_max_range: assert property (maxt_r >= sctm_pkg::MAXT_MIN
    && maxt_r <= sctm_pkg::MAXT_MAX && mint_r <= maxt_r && mint_r >= sctm_pkg::MAXT_MIN)
    else $error("time limits out of range");
  a_no_fill: assert property (state_r == sctm_pkg::ST_SCAN && cmd[0] && !ovr_ev
    && !ctrl_r[sctm_pkg::CTRL_FIX_EN] |=> state_r == sctm_pkg::ST_SCAN
    && scan_ms_r == 13'h0000 && !ovr_seen_r)
    else $error("next scan not started at once");

  c_overrun_hdl: cover property (ovr_ev && ctrl_r[sctm_pkg::CTRL_HANDLER]);
  c_double:      cover property (ovr_ev && ovr_seen_r);
  c_fill:        cover property (state_r == sctm_pkg::ST_IDLE ##1 scan_start_o);
  c_slice:       cover property ($rose(comm_slice_o));
endmodule : sctm_top
`default_nettype wire

// [hdl/sctm_pkg.sv]
// sctm_pkg: shared constants of the scan cycle time monitor
// assumes a 50 MHz system clock and a 32-bit memory-mapped register bus
package sctm_pkg;
  // timing
  localparam int unsigned CLK_NS     = 20;
  localparam int unsigned MS_NS      = 1_000_000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
  localparam int unsigned SLICE_MS   = 100;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MAXT = 5'h04;
  localparam logic [4:0] OFF_MINT = 5'h08;
  localparam logic [4:0] OFF_COMM = 5'h0C;
  localparam logic [4:0] OFF_CMD  = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  // ctrl fields
  localparam int unsigned CTRL_START_DONE = 0;
  localparam int unsigned CTRL_HANDLER    = 1;
  localparam int unsigned CTRL_FIX_EN     = 2;
  // cmd fields (write one to act)
  localparam int unsigned CMD_SCAN_END    = 0;
  localparam int unsigned CMD_RETRIG      = 1;
  localparam int unsigned CMD_RETRIG_HCTX = 2;
  localparam int unsigned CMD_HDL_DONE    = 3;
  localparam int unsigned CMD_RESTART     = 4;
  // limits and reset values
  localparam logic [12:0] MAXT_MIN   = 13'h0001;
  localparam logic [12:0] MAXT_MAX   = 13'h1770;
  localparam logic [12:0] MAXT_RST   = 13'h0096;
  localparam logic [12:0] MINT_RST   = 13'h0001;
  localparam logic [6:0]  COMM_RST   = 7'h14;
  localparam logic [6:0]  COMM_MAX   = 7'h64;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [7:0]  CAUSE_MAXT = 8'h01;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_SCAN = 2'b01,
    ST_IDLE = 2'b10,
    ST_STOP = 2'b11
  } sctm_state_e;
endpackage : sctm_pkg

// [tb/testbench.sv]
// testbench: self-checking bench for the scan cycle time monitor
// assumes sctm_top with CYC_MS shrunk so that one millisecond is 20 clock cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %0h want %0h", $time, a, b); end end
module testbench;
  localparam int MS = 20;
  logic        clk_i;
  logic        rst_i;
  logic [4:0]  address_i;
  logic        read_i;
  logic        write_i;
  logic [31:0] writedata_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        stop_o;
  logic        handler_req_o;
  logic [7:0]  fault_cause_code_o;
  logic        idle_fill_o;
  logic        scan_start_o;
  logic        comm_slice_o;
  logic [31:0] d;
  int          fails;
  int          tests_run;
  int          cyc = 0;
  int          t0;
  int          n;

  sctm_top #(.CYC_MS(MS)) i_sctm_top (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .stop_o(stop_o),
    .handler_req_o(handler_req_o), .fault_cause_code_o(fault_cause_code_o),
    .idle_fill_o(idle_fill_o), .scan_start_o(scan_start_o), .comm_slice_o(comm_slice_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // free cycle count, read at edges so its pre-edge value is consistent
  always @(posedge clk_i) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task timeout;
    fails++;
    $display("Error %0t: wait ran out", $time);
    report_and_stop();
  endtask : timeout

  task do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // request held until waitrequest is sampled low, no latency assumed
  task bus_xfer(input logic we, input logic [4:0] a, input logic [31:0] wd,
                output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= wd;
    write_i     <= we;
    read_i      <= ~we;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
      if (k > 20) timeout();
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask : bus_xfer

  function automatic logic sel(input int w);
    case (w)
      0:       return scan_start_o;
      1:       return stop_o;
      default: return handler_req_o;
    endcase
  endfunction : sel

  task wait_hi(input int w, input int lim);
    int k;
    k = 0;
    while (sel(w) !== 1'b1)
    begin
      @(posedge clk_i);
      k++;
      if (k > lim) timeout();
    end
  endtask : wait_hi

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    do_reset();
    bus_xfer(0, sctm_pkg::OFF_CTRL, 0, d);
    `CHK(d[2:0], 3'h0)
    bus_xfer(0, sctm_pkg::OFF_MAXT, 0, d);
    `CHK(d[12:0], 13'h0096)
    bus_xfer(0, 5'h18, 0, d);
    `CHK(d, 32'h0000_0000)
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_1FFF, d);
    bus_xfer(0, sctm_pkg::OFF_MAXT, 0, d);
    `CHK(d[12:0], 13'h1770)
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_0000, d);
    bus_xfer(0, sctm_pkg::OFF_MAXT, 0, d);
    `CHK(d[12:0], 13'h0001)
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_0005, d);
    bus_xfer(1, sctm_pkg::OFF_MINT, 32'h0000_1FFF, d);
    bus_xfer(0, sctm_pkg::OFF_MINT, 0, d);
    `CHK(d[12:0], 13'h0005)
    // startup not marked done, so no scan and no supervision may start
    repeat (8 * MS)
    begin
      @(posedge clk_i);
      `CHK(scan_start_o | stop_o, 1'b0)
    end
  endtask : t_regs

  task t_overrun_stop;
    do_reset();
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_0003, d);
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0001, d);
    wait_hi(0, 10);
    t0 = cyc;
    wait_hi(1, 10 * MS);
    n = cyc - t0;
    `CHK(handler_req_o, 1'b0)
    `CHK(n inside {[3 * MS - 3 : 3 * MS + 3]}, 1'b1)
  endtask : t_overrun_stop

  task t_handler;
    do_reset();
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_0002, d);
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0003, d);
    wait_hi(2, 5 * MS);
    `CHK(fault_cause_code_o, 8'h01)
    `CHK(stop_o, 1'b0)
    // handler done withdraws the request but the overrun stays counted
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0008, d);
    @(posedge clk_i);
    `CHK(handler_req_o, 1'b0)
    // retriggers from handler context must not hold off the second overrun
    repeat (20) bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0006, d);
    `CHK(stop_o, 1'b1)
    // restart leaves stop through startup into a fresh scan
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0010, d);
    wait_hi(0, 10);
    `CHK(stop_o | handler_req_o, 1'b0)
  endtask : t_handler

  task t_retrigger;
    do_reset();
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_0002, d);
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0003, d);
    wait_hi(0, 10);
    repeat (30)
    begin
      bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0002, d);
      `CHK(handler_req_o | stop_o, 1'b0)
    end
    wait_hi(2, 3 * MS);
    // a retrigger between two overruns forgives the first one
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0002, d);
    repeat (50) @(posedge clk_i);
    `CHK(stop_o, 1'b0)
  endtask : t_retrigger

  task t_fixed_min;
    do_reset();
    bus_xfer(1, sctm_pkg::OFF_MAXT, 32'h0000_000A, d);
    bus_xfer(1, sctm_pkg::OFF_MINT, 32'h0000_0004, d);
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0005, d);
    wait_hi(0, 10);
    t0 = cyc;
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0001, d);
    @(posedge clk_i);
    `CHK(idle_fill_o, 1'b1)
    wait_hi(0, 8 * MS);
    n = cyc - t0;
    `CHK(n inside {[3 * MS : 5 * MS]}, 1'b1)
    repeat (6 * MS) @(posedge clk_i);
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0001, d);
    wait_hi(0, 6);
    `CHK(idle_fill_o | stop_o | handler_req_o, 1'b0)
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0001, d);
    bus_xfer(1, sctm_pkg::OFF_CMD, 32'h0000_0001, d);
    wait_hi(0, 6);
    `CHK(idle_fill_o, 1'b0)
  endtask : t_fixed_min

  task t_comm_slice;
    do_reset();
    bus_xfer(1, sctm_pkg::OFF_COMM, 32'h0000_00FF, d);
    bus_xfer(0, sctm_pkg::OFF_COMM, 0, d);
    `CHK(d[6:0], 7'h64)
    bus_xfer(1, sctm_pkg::OFF_COMM, 32'h0000_0014, d);
    bus_xfer(1, sctm_pkg::OFF_CTRL, 32'h0000_0001, d);
    wait_hi(0, 10);
    // one full frame inside a long scan that never ends
    n = 0;
    repeat (100 * MS)
    begin
      @(posedge clk_i);
      n += int'(comm_slice_o === 1'b1);
    end
    `CHK(n inside {[20 * MS - 2 : 20 * MS + 2]}, 1'b1)
  endtask : t_comm_slice

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i       = 1'b1;
    address_i   = 5'h00;
    read_i      = 1'b0;
    write_i     = 1'b0;
    writedata_i = 32'h0000_0000;
    fails       = 0;
    tests_run   = 0;
    t_regs();
    t_overrun_stop();
    t_handler();
    t_retrigger();
    t_fixed_min();
    t_comm_slice();
    report_and_stop();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
